//--- hw/cim_pkg.sv
// package for the command-driven i2c master: register map, command bits,
// status codes, timing constants and the bus carrier structs.
// assumes a 50 MHz ref_clk and 32-bit apb data.
`default_nettype none
package cim_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CIM_BIT_DURATION_ADDR = 12'h000;
  localparam logic [11:0] CIM_COMMAND_ADDR = 12'h004;
  localparam logic [11:0] CIM_STATUS_ADDR = 12'h008;
  localparam logic [11:0] CIM_TARGET_ADDR_ADDR = 12'h00C;
  localparam logic [11:0] CIM_RX_BYTE_ADDR = 12'h010;
  localparam logic [11:0] CIM_TX_BYTE_ADDR = 12'h014;
  localparam logic [7:0] CIM_RESET_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // command bits
  // ----------------------------------------------------------------
  localparam int CIM_CMD_START_BIT = 5;
  localparam int CIM_CMD_STOP_BIT = 4;
  localparam int CIM_CMD_ADDR_BIT = 3;
  localparam int CIM_CMD_DATA_BIT = 2;
  localparam int CIM_CMD_RD_ACK_BIT = 1;
  localparam int CIM_CMD_RD_NACK_BIT = 0;
  localparam logic [7:0] CIM_CMD_START = 8'h20;
  localparam logic [7:0] CIM_CMD_STOP = 8'h10;
  localparam logic [7:0] CIM_CMD_ADDR = 8'h08;
  localparam logic [7:0] CIM_CMD_DATA = 8'h04;
  localparam logic [7:0] CIM_CMD_RD_ACK = 8'h02;
  localparam logic [7:0] CIM_CMD_RD_NACK = 8'h01;
  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CIM_ST_IDLE = 8'h00;
  localparam logic [7:0] CIM_ST_START = 8'h01;
  localparam logic [7:0] CIM_ST_RSTART = 8'h02;
  localparam logic [7:0] CIM_ST_WADDR_ACK = 8'h34;
  localparam logic [7:0] CIM_ST_RADDR_ACK = 8'h2C;
  localparam logic [7:0] CIM_ST_WADDR_NACK = 8'h54;
  localparam logic [7:0] CIM_ST_RADDR_NACK = 8'h4C;
  localparam logic [7:0] CIM_ST_ADDR_ERR = 8'hE4;
  localparam logic [7:0] CIM_ST_RD_ACK = 8'h48;
  localparam logic [7:0] CIM_ST_RD_NACK = 8'h28;
  localparam logic [7:0] CIM_ST_WD_ACK = 8'h30;
  localparam logic [7:0] CIM_ST_WD_NACK = 8'h50;
  localparam logic [7:0] CIM_ST_WD_ERR = 8'hF0;
  localparam logic [7:0] CIM_ST_GEN_ERR = 8'hFF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CIM_CLK_HZ = 50000000;
  localparam int CIM_UNIT_US = 1;
  localparam int CIM_CYC_PER_US = CIM_CLK_HZ / 1000000 * CIM_UNIT_US;
  // one microsecond split in four quarter slots of the bit
  localparam logic [3:0] CIM_QUARTER_CYC = 4'(CIM_CYC_PER_US / 4);
  localparam logic [3:0] CIM_QUARTER_LAST = 4'(CIM_CYC_PER_US / 4 - 1);
  // high quarters take the odd cycle, so one bit is one microsecond
  localparam logic [3:0] CIM_HIGH_QUARTER_LAST =
    4'(CIM_CYC_PER_US / 2 - CIM_CYC_PER_US / 4 - 1);
  localparam logic [3:0] CIM_BIT_LAST = 4'h7;
  localparam logic [3:0] CIM_ACK_SLOT = 4'h8;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cim_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cim_apb_rsp_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } cim_pin_out_t;
endpackage
`default_nettype wire

//--- hw/cim_sync.sv
// two-flop synchroniser for the serial clock and data pins.
// assumes the pins are asynchronous to ref_clk.
`default_nettype none
module cim_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pins in, synchronised out
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_sync
);
  import cim_pkg::*;
  logic [1:0] stage1_reg;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      stage1_reg <= 2'h3;
      pin_sync <= 2'h3;
    end
    else
    begin
      stage1_reg <= pin_in;
      pin_sync <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

//--- hw/cim_master.sv
// command-driven i2c master with an apb register file.
// assumes an open-drain bus with external pull-ups; pins only pull low.
// Function
// - zero bit duration blocks all bus traffic
// - each bit lasts N microseconds
// - start or repeated start on bit 5
// - stop condition on bit 4, releases bus
// - send address byte, sample acknowledge
// - send transmit byte, sample acknowledge
// - receive byte with ACK or NACK
// - one command bit per command
// - status bits encode error, ack, mode
// - start completion sets status bits 0/1
// - byte completion shown by bits 2..6
// - composite status codes as listed
// - address bits 7..1, bit 0 direction
// - receive register holds last byte
//
// The register offsets and the APB register port were left to the implementer.
`default_nettype none
module cim_master (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire cim_pkg::cim_apb_req_t apb_req,
  output cim_pkg::cim_apb_rsp_t apb_rsp,
  // open-drain i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output cim_pkg::cim_pin_out_t pins,
  // activity
  output logic busy
);
  import cim_pkg::*;

  typedef enum {
    CIM_IDLE, CIM_START, CIM_BYTE, CIM_STOP
  } cim_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_one_hot(input logic [7:0] v);
    is_one_hot = (v != CIM_RESET_BYTE) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  logic [7:0] bit_duration_reg;
  logic [7:0] target_address_reg;
  logic [7:0] transmit_byte_reg;
  logic [7:0] receive_byte_reg;
  logic [7:0] status_reg;
  cim_state_t state_reg;
  logic [7:0] cmd_reg;
  logic open_reg;
  logic [1:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic [3:0] sub_reg;
  logic [7:0] us_reg;
  logic [1:0] phase_reg;
  logic [3:0] bitn_reg;
  logic [7:0] shift_reg;
  logic scl_o_reg;
  logic sda_o_reg;
  logic ack_seen_reg;
  logic wr_en;
  logic [31:0] prdata_reg;
  logic quarter_end;
  logic [3:0] sub_last;
  logic bit_end;
  logic cmd_fire;

  cim_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in({scl_i, sda_i}),
    .pin_sync(pin_sync)
  );
  assign scl_s = pin_sync[1];
  assign sda_s = pin_sync[0];

  // ----------------------------------------------------------------
  // apb slave: zero wait states, unmapped reads zero, no error
  // ----------------------------------------------------------------
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rsp = '{1'b1, 1'b0, prdata_reg};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      prdata_reg <= 32'h0000_0000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    begin
      if (apb_req.paddr == CIM_BIT_DURATION_ADDR)
        prdata_reg <= {24'h000000, bit_duration_reg};
      else if (apb_req.paddr == CIM_STATUS_ADDR)
        prdata_reg <= {24'h000000, status_reg};
      else if (apb_req.paddr == CIM_TARGET_ADDR_ADDR)
        prdata_reg <= {24'h000000, target_address_reg};
      else if (apb_req.paddr == CIM_RX_BYTE_ADDR)
        prdata_reg <= {24'h000000, receive_byte_reg};
      else
        prdata_reg <= 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bit_duration_reg <= CIM_RESET_BYTE;
      target_address_reg <= CIM_RESET_BYTE;
      transmit_byte_reg <= CIM_RESET_BYTE;
    end
    else if (wr_en)
    begin
      if (apb_req.paddr == CIM_BIT_DURATION_ADDR)
        bit_duration_reg <= apb_req.pwdata[7:0];
      else if (apb_req.paddr == CIM_TARGET_ADDR_ADDR)
        target_address_reg <= apb_req.pwdata[7:0];
      else if (apb_req.paddr == CIM_TX_BYTE_ADDR)
        transmit_byte_reg <= apb_req.pwdata[7:0];
    end
  end

  // accepted only when idle, enabled and exactly one bit set
  assign cmd_fire = wr_en && (apb_req.paddr == CIM_COMMAND_ADDR)
    && (state_reg == CIM_IDLE)
    && (bit_duration_reg != CIM_RESET_BYTE)
    && is_one_hot(apb_req.pwdata[7:0]);
  assign busy = (state_reg != CIM_IDLE);

  // ----------------------------------------------------------------
  // timebase: quarter-bit ticks of N/4 microseconds
  // ----------------------------------------------------------------
  // low quarters take 12 cycles per unit, high ones 13: a bit is N us
  assign sub_last = phase_reg[1] ? CIM_HIGH_QUARTER_LAST : CIM_QUARTER_LAST;
  assign quarter_end = (sub_reg == sub_last)
    && (us_reg == bit_duration_reg - 8'h01);
  assign bit_end = quarter_end && (phase_reg == 2'h3);

  always_ff @(posedge ref_clk)
  begin
    if (rst || state_reg == CIM_IDLE)
    begin
      sub_reg <= 4'h0;
      us_reg <= 8'h00;
      phase_reg <= 2'h0;
    end
    else if (sub_reg == sub_last)
    begin
      sub_reg <= 4'h0;
      if (quarter_end)
      begin
        us_reg <= 8'h00;
        phase_reg <= phase_reg + 2'h1;
      end
      else
        us_reg <= us_reg + 8'h01;
    end
    else
      sub_reg <= sub_reg + 4'h1;
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // phases: 0 scl low (sda moves), 1 scl low, 2 scl high, 3 scl high
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg <= CIM_IDLE;
      cmd_reg <= CIM_RESET_BYTE;
      open_reg <= 1'b0;
      bitn_reg <= 4'h0;
      shift_reg <= CIM_RESET_BYTE;
      scl_o_reg <= 1'b1;
      sda_o_reg <= 1'b1;
      ack_seen_reg <= 1'b0;
      receive_byte_reg <= CIM_RESET_BYTE;
      status_reg <= CIM_ST_IDLE;
    end
    else
    begin
      case (state_reg)
        CIM_IDLE:
        begin
          if (cmd_fire)
          begin
            cmd_reg <= apb_req.pwdata[7:0];
            bitn_reg <= 4'h0;
            if (apb_req.pwdata[CIM_CMD_START_BIT])
              state_reg <= CIM_START;
            else if (apb_req.pwdata[CIM_CMD_STOP_BIT])
              state_reg <= CIM_STOP;
            else if (!open_reg)
              status_reg <= CIM_ST_GEN_ERR; // byte command without start
            else
            begin
              state_reg <= CIM_BYTE;
              if (apb_req.pwdata[CIM_CMD_ADDR_BIT])
                shift_reg <= target_address_reg;
              else if (apb_req.pwdata[CIM_CMD_DATA_BIT])
                shift_reg <= transmit_byte_reg;
              else
                shift_reg <= 8'hFF; // release sda while reading
            end
          end
        end
        CIM_START:
        begin
          // sda high in low half, falls while scl high
          if (quarter_end)
          begin
            case (phase_reg)
              2'h0: sda_o_reg <= 1'b1;
              2'h1: scl_o_reg <= 1'b1;
              2'h2: sda_o_reg <= 1'b0;
              default:
              begin
                scl_o_reg <= 1'b0;
                state_reg <= CIM_IDLE;
                open_reg <= 1'b1;
                status_reg <= open_reg ? CIM_ST_RSTART : CIM_ST_START;
              end
            endcase
          end
        end
        CIM_STOP:
        begin
          if (quarter_end)
          begin
            case (phase_reg)
              2'h0: sda_o_reg <= 1'b0;
              2'h1: scl_o_reg <= 1'b1;
              2'h2: sda_o_reg <= 1'b1;
              default:
              begin
                state_reg <= CIM_IDLE;
                open_reg <= 1'b0;
                status_reg <= CIM_ST_IDLE;
              end
            endcase
          end
        end
        CIM_BYTE:
        begin
          if (quarter_end)
          begin
            case (phase_reg)
              2'h0:
              begin
                if (bitn_reg == CIM_ACK_SLOT)
                  sda_o_reg <= !(cmd_reg[CIM_CMD_RD_ACK_BIT]
                    || cmd_reg[CIM_CMD_RD_NACK_BIT])
                    || cmd_reg[CIM_CMD_RD_NACK_BIT];
                else
                  sda_o_reg <= shift_reg[7];
              end
              2'h1: scl_o_reg <= 1'b1;
              2'h2:
              begin
                if (bitn_reg == CIM_ACK_SLOT)
                  ack_seen_reg <= !sda_s;
                else
                  shift_reg <= {shift_reg[6:0], sda_s};
              end
              default:
              begin
                scl_o_reg <= 1'b0;
                if (bitn_reg == CIM_ACK_SLOT)
                  state_reg <= CIM_IDLE;
                else
                  bitn_reg <= bitn_reg + 4'h1;
              end
            endcase
          end
          // completion codes at the end of the ack bit
          if (bit_end && bitn_reg == CIM_ACK_SLOT)
          begin
            if (cmd_reg[CIM_CMD_ADDR_BIT])
            begin
              if (!scl_s)
                status_reg <= CIM_ST_ADDR_ERR;
              else if (target_address_reg[0])
                status_reg <= ack_seen_reg ? CIM_ST_RADDR_ACK
                  : CIM_ST_RADDR_NACK;
              else
                status_reg <= ack_seen_reg ? CIM_ST_WADDR_ACK
                  : CIM_ST_WADDR_NACK;
            end
            else if (cmd_reg[CIM_CMD_DATA_BIT])
            begin
              if (!scl_s)
                status_reg <= CIM_ST_WD_ERR;
              else
                status_reg <= ack_seen_reg ? CIM_ST_WD_ACK : CIM_ST_WD_NACK;
            end
            else
            begin
              receive_byte_reg <= shift_reg;
              status_reg <= cmd_reg[CIM_CMD_RD_ACK_BIT] ? CIM_ST_RD_ACK
                : CIM_ST_RD_NACK;
            end
          end
        end
        default: state_reg <= CIM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pins: open drain, enable only to pull low
  // ----------------------------------------------------------------
  assign pins.scl_o = 1'b0;
  assign pins.sda_o = 1'b0;
  assign pins.scl_oe = !scl_o_reg;
  assign pins.sda_oe = !sda_o_reg;
endmodule
`default_nettype wire

//--- sim/cim_master_asserts.sv
// checker for the i2c master: apb answer, refusals and bit length.
// sees only the top ports; bound to the master below.
`default_nettype none
module cim_master_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire cim_pkg::cim_apb_req_t apb_req,
  input wire cim_pkg::cim_apb_rsp_t apb_rsp,
  // bus and activity
  input wire logic scl_i,
  input wire logic sda_i,
  input wire cim_pkg::cim_pin_out_t pins,
  input wire logic busy
);
  import cim_pkg::*;
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  logic [7:0] dur_reg;
  logic [7:0] cmd_reg;
  logic [17:0] cnt_reg;
  logic [17:0] len;
  logic wr;
  logic cw;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign cw = wr && apb_req.paddr == CIM_COMMAND_ADDR;
  // start and stop last one bit, byte commands nine
  assign len = (cmd_reg[5] || cmd_reg[4]) ?
    18'(CIM_CYC_PER_US) * dur_reg : 18'(9 * CIM_CYC_PER_US) * dur_reg;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      dur_reg <= 8'h00;
    else if (wr && apb_req.paddr == CIM_BIT_DURATION_ADDR)
      dur_reg <= apb_req.pwdata[7:0];
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cmd_reg <= 8'h00;
    else if (cw && !busy)
      cmd_reg <= apb_req.pwdata[7:0];
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cnt_reg <= 18'd0;
    else
      cnt_reg <= busy ? cnt_reg + 18'd1 : 18'd0;
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_cmd(logic c);
    cw && !busy && c;
  endsequence
  sequence s_quiet;
    !busy [*3];
  endsequence
  a_zero_blocks: assert property (
    s_cmd(dur_reg == 8'h00) |=> s_quiet)
    else $error("command ran with zero bit duration");
  a_start_runs: assert property (
    s_cmd(dur_reg != 8'h00 && apb_req.pwdata[7:0] == CIM_CMD_START)
    |=> busy)
    else $error("start command not taken");
  a_one_bit: assert property (
    s_cmd($countones(apb_req.pwdata[7:0]) != 1) |=> s_quiet)
    else $error("command with other than one bit ran");
  a_bit_length: assert property (
    $fell(busy) && cnt_reg > 18'd4 |->
    cnt_reg + 18'd2 >= len && cnt_reg <= len + 18'd2)
    else $error("command length off from bit duration");
  a_idle_still: assert property (
    !busy && !$past(busy) |->
    $stable(pins.scl_oe) && $stable(pins.sda_oe))
    else $error("bus moved with no command running");
  a_reset_free: assert property (
    $fell(rst) |-> !pins.scl_oe && !pins.sda_oe && !busy)
    else $error("bus not released after reset");
  a_ready_const: assert property (
    apb_req.psel |-> apb_rsp.pready && !apb_rsp.pslverr)
    else $error("apb answer not ready or in error");
  a_read_upper: assert property (
    apb_req.psel && apb_req.penable && !apb_req.pwrite |->
    apb_rsp.prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_pins_low: assert property (!pins.scl_o && !pins.sda_o)
    else $error("pin drives high");
endmodule
bind cim_master cim_master_asserts i_cim_master_asserts (
  .ref_clk(ref_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .scl_i(scl_i), .sda_i(sda_i), .pins(pins), .busy(busy));
`default_nettype wire

//--- sim/cim_i2c_target.sv
// behavioural i2c target: acks its address and written bytes,
// serves counting bytes on reads. only pulls sda low (pull-up wire).
`default_nettype none
module cim_i2c_target #(
  parameter logic [6:0] OWN_ADDR = 7'h50,
  parameter logic [7:0] FIRST_RD = 8'hA5
) (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  // pull and capture
  output logic sda_oe,
  output logic [7:0] last_wr
);
  // ------------------------------------------------
  // protocol
  // ------------------------------------------------
  int cnt;
  logic [7:0] sh;
  logic [7:0] rd_val;
  logic act, hdr, hit, rd;
  initial
  begin
    sda_oe = 1'b0;
    last_wr = 8'h00;
    rd_val = FIRST_RD;
    sh = 8'h00;
    {act, hdr, hit, rd} = 4'h0;
    cnt = 0;
  end
  // the fall of scl right after start is not a bit
  always @(negedge sda)
  begin
    if (scl)
    begin
      {act, hdr, hit, rd} = 4'hC;
      cnt = -1;
    end
  end
  always @(posedge sda)
  begin
    if (scl)
      act = 1'b0;
  end
  always @(posedge scl)
  begin
    if (act && cnt < 8)
      sh = {sh[6:0], sda};
    // a master nack ends the read, so the line is let go after it
    if (act && cnt == 8 && rd && sda)
      hit = 1'b0;
  end
  always @(negedge scl)
  begin
    if (act)
    begin
      cnt++;
      sda_oe = 1'b0;
      if (cnt == 8 && hdr)
      begin
        hit = sh[7:1] == OWN_ADDR;
        rd = sh[0];
        hdr = 1'b0;
        sda_oe = hit;
      end
      else if (cnt == 8 && hit && !rd)
      begin
        last_wr = sh;
        sda_oe = 1'b1;
      end
      else if (cnt == 8 && rd)
        rd_val = rd_val + 8'h01;
      if (cnt == 9)
        cnt = 0;
      if (hit && rd && cnt < 8)
        sda_oe = !rd_val[7 - cnt];
    end
  end
endmodule
`default_nettype wire

//--- sim/testbench.sv
// testbench for the i2c master: apb register access and bus transfers
// against a behavioural target on open-drain wires with pull-ups.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cim_pkg::*;
  `define CHK(n, e, g) begin checks++; \
    if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, g); end end
  // ------------------------------------------------
  // harness
  // ------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst;
  cim_apb_req_t req;
  cim_apb_rsp_t rsp;
  cim_pin_out_t pins;
  logic busy;
  logic tgt_oe;
  // stands in for a target that holds the clock low
  logic hold_scl;
  logic [7:0] tgt_wr;
  wire logic scl_w;
  wire logic sda_w;
  int error_cnt;
  int checks;
  assign scl_w = !(pins.scl_oe || hold_scl);
  assign sda_w = !(pins.sda_oe || tgt_oe);
  always #10 ref_clk = !ref_clk;
  cim_master i_cim_master (.ref_clk(ref_clk), .rst(rst), .apb_req(req),
    .apb_rsp(rsp), .scl_i(scl_w), .sda_i(sda_w), .pins(pins),
    .busy(busy));
  cim_i2c_target i_cim_i2c_target (.scl(scl_w), .sda(sda_w),
    .sda_oe(tgt_oe), .last_wr(tgt_wr));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d, output logic [7:0] q);
    req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    @(posedge ref_clk);
    while (rsp.pready !== 1'b1)
      @(posedge ref_clk);
    q = rsp.prdata[7:0];
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdchk(input string n, input logic [11:0] a,
    input logic [7:0] e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    `CHK(n, e, q)
  endtask
  task automatic idle;
    while (busy !== 1'b0)
      @(posedge ref_clk);
  endtask
  task automatic step(input logic [7:0] c, input logic [7:0] e);
    wr(CIM_COMMAND_ADDR, c);
    idle;
    rdchk("status", CIM_STATUS_ADDR, e);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------
  // scenarios
  // ------------------------------------------------
  task automatic t_reset;
    rdchk("status", CIM_STATUS_ADDR, CIM_ST_IDLE);
    rdchk("dur", CIM_BIT_DURATION_ADDR, 8'h00);
    rdchk("unmapped", 12'h020, 8'h00);
    wr(CIM_TARGET_ADDR_ADDR, 8'hA0);
    rdchk("addr", CIM_TARGET_ADDR_ADDR, 8'hA0);
  endtask
  task automatic t_zero;
    wr(CIM_COMMAND_ADDR, CIM_CMD_START);
    `CHK("busy", 1'b0, busy)
    rdchk("status", CIM_STATUS_ADDR, CIM_ST_IDLE);
    `CHK("sda", 1'b1, sda_w)
  endtask
  task automatic t_refuse;
    wr(CIM_BIT_DURATION_ADDR, 8'h01);
    wr(CIM_COMMAND_ADDR, 8'h30);
    `CHK("busy", 1'b0, busy)
    step(CIM_CMD_DATA, CIM_ST_GEN_ERR);
    step(CIM_CMD_STOP, CIM_ST_IDLE);
  endtask
  task automatic t_write;
    step(CIM_CMD_START, CIM_ST_START);
    step(CIM_CMD_ADDR, CIM_ST_WADDR_ACK);
    wr(CIM_TX_BYTE_ADDR, 8'h12);
    wr(CIM_COMMAND_ADDR, CIM_CMD_DATA);
    // a stop while busy must be dropped
    wr(CIM_COMMAND_ADDR, CIM_CMD_STOP);
    idle;
    rdchk("status", CIM_STATUS_ADDR, CIM_ST_WD_ACK);
    `CHK("wr_byte", 8'h12, tgt_wr)
  endtask
  task automatic t_read;
    step(CIM_CMD_START, CIM_ST_RSTART);
    wr(CIM_TARGET_ADDR_ADDR, 8'hA1);
    step(CIM_CMD_ADDR, CIM_ST_RADDR_ACK);
    step(CIM_CMD_RD_ACK, CIM_ST_RD_ACK);
    rdchk("rx", CIM_RX_BYTE_ADDR, 8'hA5);
    step(CIM_CMD_RD_NACK, CIM_ST_RD_NACK);
    rdchk("rx", CIM_RX_BYTE_ADDR, 8'hA6);
    step(CIM_CMD_STOP, CIM_ST_IDLE);
    `CHK("wire", 2'b11, {scl_w, sda_w})
  endtask
  task automatic t_nack;
    step(CIM_CMD_START, CIM_ST_START);
    wr(CIM_TARGET_ADDR_ADDR, 8'hB0);
    step(CIM_CMD_ADDR, CIM_ST_WADDR_NACK);
    wr(CIM_TX_BYTE_ADDR, 8'h5A);
    step(CIM_CMD_DATA, CIM_ST_WD_NACK);
    step(CIM_CMD_START, CIM_ST_RSTART);
    wr(CIM_TARGET_ADDR_ADDR, 8'hB1);
    step(CIM_CMD_ADDR, CIM_ST_RADDR_NACK);
    step(CIM_CMD_STOP, CIM_ST_IDLE);
  endtask
  // clock held low through the ack bit gives the error codes
  task automatic t_err;
    step(CIM_CMD_START, CIM_ST_START);
    hold_scl <= 1'b1;
    step(CIM_CMD_ADDR, CIM_ST_ADDR_ERR);
    step(CIM_CMD_DATA, CIM_ST_WD_ERR);
    hold_scl <= 1'b0;
    step(CIM_CMD_STOP, CIM_ST_IDLE);
  endtask
  // ------------------------------------------------
  // main
  // ------------------------------------------------
  initial
  begin
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    req = '0;
    hold_scl = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_zero;
    t_refuse;
    t_write;
    t_read;
    t_nack;
    t_err;
    close_out;
  end
  initial
  begin
    #1000000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
